// File: hdl/spf_engine.sv
// Purpose: Serial frame engine for SPI, SSP and three-wire formats
// Assumes: Link pins asynchronous; 200 MHz clock
// Notes:   Master drives the clock; slave follows sampled pins
`timescale 1ns/1ps
`default_nettype none
`include "spf_map.svh"

module spf_engine
  import spf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic        master_mode,
  input  wire logic [1:0]  frame_format,
  input  wire logic        clock_idle_polarity,
  input  wire logic        clock_capture_phase,
  input  wire logic [3:0]  frame_length,
  input  wire logic [3:0]  control_word_length,
  input  wire logic        data_direction_select,
  input  wire logic        sequential_transfer_mode,
  input  wire logic        ready_handshake_enable,
  input  wire logic [15:0] frame_count_register,
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_valid,
  output var  logic        tx_ready,
  output var  logic [15:0] rx_data,
  output var  logic        rx_valid,
  input  wire logic        rx_ready,
  output var  logic        busy,
  input  wire logic        serial_clock_line_in,
  output var  logic        serial_clock_line_out,
  output var  logic        serial_clock_line_oe,
  input  wire logic        slave_select_pin_in,
  output var  logic        slave_select_pin_out,
  output var  logic        slave_select_pin_oe,
  output var  logic        serial_transmit_line_out,
  output var  logic        serial_transmit_line_oe,
  input  wire logic        serial_receive_line_in,
  input  wire logic        handshake_ready_in
);

  // ****************************************
  // Declarations
  // ****************************************
  spf_state_type state_reg, state_next;
  logic [`SPF_SYNC_W-1:0] pins_sync;
  logic        sclk_s, sel_s, rx_s, rdy_s;
  logic        is_ssp, is_mw, pol_eff, cpha_eff, rx_bits;
  logic [3:0]  df_len;
  logic [5:0]  dat_bit, last_bit, bit_reg;
  logic [7:0]  half_cnt_reg;
  logic        tick, at_last, cont, cont_ok, mw_more;
  logic        m_lead, m_trail, s_lead, s_trail, ev_lead, ev_trail;
  logic        m_start, s_start, m_load, wrap, samp_now, push;
  logic        drv_now, load_ctl, load_dat, pop;
  logic [5:0]  drv_idx;
  logic [15:0] new_word, src, rx_word, rx_mask;
  logic [15:0] hold_reg, last_word_reg, tx_shift_reg, rx_shift_reg;
  logic [15:0] frame_cnt_reg;
  logic        hold_full_reg, sclk_prev_reg, sel_prev_reg, fs_reg, fs_next;
  logic        frame_next, rx_in_ready;

  // Data word sits MSB-first at the top of the shifter
  function automatic logic [15:0] align(input logic [15:0] w, input logic [3:0] n);
    align = w << (4'hf - n);
  endfunction

  // Whether the device drives a data bit at this bit index
  function automatic logic carries(input logic [5:0] b);
    if (is_mw) begin
      carries = (b < dat_bit - 6'h1) || (b >= dat_bit && data_direction_select);
    end else begin
      carries = (b >= dat_bit);
    end
  endfunction

  // ****************************************
  // Pin synchronisers and mode decode
  // ****************************************
  // pins synchronised
  spf_sync #(
    .WIDTH (`SPF_SYNC_W)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({handshake_ready_in, serial_receive_line_in,
                slave_select_pin_in, serial_clock_line_in}),
    .sync_out (pins_sync)
  );

  assign sclk_s = pins_sync[0];
  assign sel_s  = pins_sync[1];
  assign rx_s   = pins_sync[2];
  assign rdy_s  = pins_sync[3];

  assign is_ssp   = master_mode && (frame_format == `SPF_FMT_SSP);
  assign is_mw    = master_mode && (frame_format == `SPF_FMT_MW);
  assign pol_eff  = (is_ssp || is_mw) ? 1'b0 : clock_idle_polarity;
  assign cpha_eff = is_ssp ? 1'b1 : (is_mw ? 1'b0 : clock_capture_phase);
  assign df_len   = (frame_length < `SPF_MIN_DFS) ? `SPF_MIN_DFS : frame_length;
  assign dat_bit  = is_mw ? ({2'h0, control_word_length} + 6'h2) : (is_ssp ? 6'h1 : 6'h0);
  assign last_bit = dat_bit + {2'h0, df_len};
  assign rx_bits  = !is_mw || !data_direction_select;
  assign at_last  = (bit_reg == last_bit);

  // ****************************************
  // Edge events
  // ****************************************
  assign tick    = (state_reg != ST_IDLE) && (half_cnt_reg == `SPF_HALF_CYC - 8'h1);
  assign m_lead  = master_mode && tick && (state_reg == ST_SHIFT) && (serial_clock_line_out == pol_eff);
  assign m_trail = master_mode && tick && (state_reg == ST_SHIFT) && (serial_clock_line_out != pol_eff);
  assign s_lead  = !master_mode && enable && !sel_s && (sclk_s != sclk_prev_reg) && (sclk_s != pol_eff);
  assign s_trail = !master_mode && enable && !sel_s && (sclk_s != sclk_prev_reg) && (sclk_s == pol_eff);
  assign ev_lead  = m_lead || s_lead;
  assign ev_trail = m_trail || s_trail;
  assign m_start = master_mode && tick && (state_reg == ST_START);
  assign s_start = !master_mode && enable && sel_prev_reg && !sel_s;
  assign m_load  = (state_next == ST_START) && (state_reg != ST_START);

  // ****************************************
  // Continuation decisions
  // ****************************************
  assign cont_ok = enable && hold_full_reg && rx_in_ready;
  assign mw_more = sequential_transfer_mode ? (frame_cnt_reg != frame_count_register)
                                            : hold_full_reg;
  always_comb begin
    if (is_ssp) begin
      cont = fs_reg;
    end else if (is_mw) begin
      cont = enable && !ready_handshake_enable && mw_more && rx_in_ready;
    end else begin
      cont = cont_ok && cpha_eff;
    end
  end
  // Slave phase 1 frames follow each other under one select
  assign wrap = ev_trail && at_last && (master_mode ? cont : cpha_eff);

  // ****************************************
  // Drive and load selection
  // ****************************************
  always_comb begin
    if (cpha_eff) begin
      drv_now = ev_lead;
      drv_idx = bit_reg;
    end else begin
      // phase 0 shifts on trailing edge
      drv_now = m_start || s_start || (ev_trail && (!at_last || wrap));
      drv_idx = (m_start || s_start) ? 6'h0 : (at_last ? 6'h0 : bit_reg + 6'h1);
    end
  end

  assign new_word = hold_full_reg ? hold_reg : last_word_reg;
  assign load_ctl = (m_load && master_mode) || (s_start && hold_full_reg) || wrap;
  assign load_dat = drv_now && is_mw && data_direction_select && (drv_idx == dat_bit);
  assign src      = load_ctl ? align(new_word, is_mw ? control_word_length : df_len)
                  : (load_dat ? align(new_word, df_len) : tx_shift_reg);
  assign pop      = (load_ctl || load_dat) && hold_full_reg;

  // ****************************************
  // Master sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (master_mode && enable && hold_full_reg && rx_in_ready) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (m_trail && at_last && !cont) begin
          state_next = (!is_ssp && !is_mw && cont_ok) ? ST_GAP : ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (tick) begin
          state_next = (is_mw && ready_handshake_enable) ? ST_WAIT_RDY : ST_IDLE;
        end
      end
      ST_GAP: begin
        if (tick) begin
          state_next = ST_START;
        end
      end
      ST_WAIT_RDY: begin
        if (rdy_s) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Half-period timer; baud rate is fixed by a constant
  always_ff @(posedge clock) begin
    if (rst || state_reg == ST_IDLE || tick) begin
      half_cnt_reg <= 8'h0;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h1;
    end
  end

  // Frame counter for sequential receive
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_cnt_reg <= 16'h0;
    end else if (m_load && state_reg == ST_IDLE) begin
      frame_cnt_reg <= 16'h0;
    end else if (wrap && is_mw) begin
      frame_cnt_reg <= frame_cnt_reg + 16'h1;
    end
  end

  // ****************************************
  // Transmit holding word
  // ****************************************
  // Ready is registered, so a word and a pop never meet in one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_reg      <= 16'h0;
      hold_full_reg <= 1'b0;
      last_word_reg <= 16'h0;
      tx_ready      <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        hold_reg      <= tx_data;
        hold_full_reg <= 1'b1;
      end else if (pop) begin
        hold_full_reg <= 1'b0;
        last_word_reg <= hold_reg;
      end
      tx_ready <= !(hold_full_reg && !pop) && !(tx_valid && tx_ready);
    end
  end

  // ****************************************
  // Bit index and shifters
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      bit_reg <= 6'h0;
    end else if (m_load || s_start) begin
      bit_reg <= 6'h0;
    end else if (ev_trail) begin
      // continued SSP frame skips its sync slot
      bit_reg <= at_last ? ((wrap && is_ssp) ? 6'h1 : 6'h0) : bit_reg + 6'h1;
    end
  end

  // Transmit shifter and data pin
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_shift_reg             <= 16'h0;
      serial_transmit_line_out <= 1'b0;
      serial_transmit_line_oe  <= 1'b0;
    end else begin
      if (drv_now && carries(drv_idx)) begin
        // first control bit after half clock
        serial_transmit_line_out <= src[15];
        tx_shift_reg             <= src << 1;
      end else if (load_ctl || load_dat) begin
        tx_shift_reg <= src;
      end
      if (drv_now) begin
        serial_transmit_line_oe <= carries(drv_idx);
      end else if (master_mode ? !frame_next : sel_s) begin
        serial_transmit_line_oe <= 1'b0;
      end
    end
  end

  assign samp_now = cpha_eff ? ev_trail : ev_lead;
  assign rx_mask  = 16'hffff >> (4'hf - df_len);
  assign rx_word  = (cpha_eff ? {rx_shift_reg[14:0], rx_s} : rx_shift_reg) & rx_mask;
  assign push     = ev_trail && at_last && rx_bits;

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_shift_reg <= 16'h0;
    end else if (samp_now && rx_bits && bit_reg >= dat_bit) begin
      rx_shift_reg <= {rx_shift_reg[14:0], rx_s};
    end
  end

  spf_fifo #(
    .WIDTH (`SPF_WORD_W),
    .DEPTH (`SPF_FIFO_DEPTH)
  ) u_rx_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_data   (rx_word),
    .in_valid  (push),
    .in_ready  (rx_in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // ****************************************
  // Clock, select and sync pins
  // ****************************************
  assign frame_next = (state_next == ST_START) || (state_next == ST_SHIFT) ||
                      (state_next == ST_TAIL);

  always_comb begin
    fs_next = fs_reg;
    if (m_start) begin
      // sync covers the whole first slot, one period, and ends on its falling edge
      fs_next = is_ssp;
    end else if (m_trail) begin
      fs_next = is_ssp && (bit_reg == last_bit - 6'h1) && cont_ok;
    end else if (state_reg == ST_IDLE) begin
      fs_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fs_reg <= 1'b0;
    end else begin
      fs_reg <= fs_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      serial_clock_line_out <= 1'b0;
    end else if (m_lead) begin
      serial_clock_line_out <= !pol_eff;
    end else if (m_trail || state_reg == ST_IDLE) begin
      serial_clock_line_out <= pol_eff;
    end
  end

  // select drops one serial clock period, eight clocks, before the first clock edge
  always_ff @(posedge clock) begin
    if (rst) begin
      slave_select_pin_out <= 1'b1;
    end else begin
      slave_select_pin_out <= is_ssp ? fs_next : !frame_next;
    end
  end

  // Pin directions, slave edge history and busy status
  always_ff @(posedge clock) begin
    if (rst) begin
      serial_clock_line_oe <= 1'b0;
      slave_select_pin_oe  <= 1'b0;
      sclk_prev_reg        <= 1'b0;
      sel_prev_reg         <= 1'b1;
      busy                 <= 1'b0;
    end else begin
      serial_clock_line_oe <= master_mode && enable;
      slave_select_pin_oe  <= master_mode && enable;
      sclk_prev_reg        <= sclk_s;
      sel_prev_reg         <= sel_s;
      busy                 <= master_mode ? (state_next != ST_IDLE) : (enable && !sel_s);
    end
  end

endmodule : spf_engine

`default_nettype wire

// File: common/spf_map.svh
// Purpose: Constants of the serial frame-format engine
// Assumes: 200 MHz system clock
// Notes:   Definitions only
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

// ****************************************
// Frame formats
// ****************************************
`define SPF_FMT_SPI       2'h0
`define SPF_FMT_SSP       2'h1
`define SPF_FMT_MW        2'h2

// ****************************************
// Widths and sizes
// ****************************************
`define SPF_WORD_W        16
`define SPF_FIFO_DEPTH    32
`define SPF_SYNC_W        4
`define SPF_MIN_DFS       4'h3

// ****************************************
// Timing
// ****************************************
`define SPF_CLK_MHZ       200
`define SPF_SCLK_HALF_NS  20
`define SPF_HALF_CYC      8'((`SPF_SCLK_HALF_NS * `SPF_CLK_MHZ) / 1000)

`endif

// File: common/spf_pkg.sv
// Purpose: Types of the serial frame-format engine
// Assumes: Nothing
// Notes:   Constants live in spf_map.svh
package spf_pkg;

  // ****************************************
  // Master sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_SHIFT,
    ST_TAIL,
    ST_GAP,
    ST_WAIT_RDY
  } spf_state_type;

endpackage : spf_pkg

// File: hdl/spf_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none

module spf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // ****************************************
  // Per-bit flop pair
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      // Metastability settles in the first stage
      always_ff @(posedge clock) begin
        if (rst) begin
          meta_reg    <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg    <= async_in[i];
          sync_out[i] <= meta_reg;
        end
      end
    end
  endgenerate

endmodule : spf_sync

`default_nettype wire

// File: hdl/spf_fifo.sv
// Purpose: Receive word FIFO with registered read data
// Assumes: Single clock
// Notes:   Output stage adds one word beyond DEPTH
`timescale 1ns/1ps
`default_nettype none
`include "spf_map.svh"

module spf_fifo #(
  parameter int WIDTH = `SPF_WORD_W,
  parameter int DEPTH = `SPF_FIFO_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             do_wr;
  logic             do_rd;

  // Full stalls the writer; the engine checks this before a frame
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign do_wr    = in_valid && in_ready;
  assign do_rd    = (count_reg != '0) && (!out_valid || out_ready);

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Registered read stage
  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (do_rd) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : spf_fifo

`default_nettype wire

// File: sim/spf_engine_asserts.sv
// Purpose: Port assertions of the frame engine
// Assumes: Bound to spf_engine, master side
// Notes:   Pins lag decisions, so idle checks wait a few cycles
`timescale 1ns/1ps
`default_nettype none
module spf_engine_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        enable,
  input wire logic        master_mode,
  input wire logic [1:0]  frame_format,
  input wire logic        clock_idle_polarity,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [15:0] rx_data,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        busy,
  input wire logic        serial_clock_line_out,
  input wire logic        slave_select_pin_out,
  input wire logic        serial_transmit_line_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire spi_m = master_mode && enable && frame_format == 2'h0;
  chk_idle_clk: assert property (
    (spi_m && !busy && $stable(clock_idle_polarity))[*3]
    |-> serial_clock_line_out == clock_idle_polarity) else $error("idle clock level wrong");
  chk_idle_sel: assert property ((spi_m && !busy)[*4]
    |-> slave_select_pin_out && !serial_transmit_line_oe) else $error("idle select wrong");
  chk_sel_busy: assert property ((spi_m && !slave_select_pin_out)[*3]
    |-> busy || $past(busy)) else $error("select low while idle");
  chk_sel_start: assert property ($rose(busy) && spi_m
    |-> ##[0:3] !slave_select_pin_out) else $error("select late");
  chk_sync_pulse: assert property (
    master_mode && frame_format == 2'h1 && $rose(slave_select_pin_out)
    |-> slave_select_pin_out[*8] ##1 !slave_select_pin_out) else $error("sync width wrong");
  chk_half_per: assert property (spi_m && busy && $changed(serial_clock_line_out)
    |=> $stable(serial_clock_line_out)[*3]) else $error("clock half period short");
  chk_tx_take: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("ready held after take");
  chk_rx_hold: assert property (rx_valid && !rx_ready
    |=> rx_valid && $stable(rx_data)) else $error("receive word lost");
  cov_spi: cover property ($rose(busy) && spi_m);
  cov_ssp: cover property (frame_format == 2'h1 && $rose(slave_select_pin_out));
  cov_mw: cover property (frame_format == 2'h2 && $fell(busy));
endmodule : spf_engine_chk
`default_nettype wire

// File: sim/spf_peer.sv
// Purpose: Behavioural serial slave on the link
// Assumes: Select active low
// Notes:   Answers the same word every frame
`timescale 1ns/1ps
`default_nettype none
module spf_peer (
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic        pol,
  input  wire logic        cpha,
  input  wire logic [3:0]  len,
  input  wire logic [15:0] word,
  input  wire logic [4:0]  skip,
  output var  logic        miso,
  output var  logic [15:0] rx
);
  int i;
  // control slots show a released 1, then the dummy 0, then data
  function automatic logic slot_bit(input int k);
    slot_bit = (k > len + 1) ? 1'b1 : ((k > len) ? 1'b0 : word[k]);
  endfunction
  initial miso = 1'b0;
  always @(negedge cs_n) begin
    i = len + skip;
    rx = 16'h0000;
    if (!cpha) miso = slot_bit(i);
  end
  // Released line flips so a stale bit never passes
  always @(posedge cs_n) miso = ~miso;
  always @(sclk) if (!cs_n) begin
    if ((sclk != pol) ^ cpha) rx = {rx[14:0], mosi};
    else if (cpha) begin
      if (i < 0) i = len;
      miso = word[i];
      i = i - 1;
    end else if (i > 0) begin
      // slave changes on the trailing edge
      i = i - 1;
      miso = slot_bit(i);
    end else begin
      // next frame follows under the same select
      i = len + skip;
      miso = slot_bit(i);
    end
  end
endmodule : spf_peer
`default_nettype wire

// File: sim/tb_spf_engine.sv
// Purpose: Self-checking bench of the frame engine
// Assumes: Master mode, peer slave on the link
// Notes:   Short frames keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_spf_engine;
  logic        clock = 0, rst = 1, pol = 0, pha = 0, seq = 0, txv = 0, rxr = 0, en = 1;
  logic        txr, rxv, busy, sk_o, sk_e, ss_o, ss_e, tx_o, tx_e, miso;
  logic [1:0]  fmt = 2'h0;
  logic [3:0]  flen = 4'h7, clen = 4'h3;
  logic [15:0] txd = 16'h0, fcnt = 16'h0, rxd, prx, rises;
  int          failures = 0, check_count = 0;
  wire         sk = sk_e ? sk_o : pol;
  wire         ss = ss_e ? ss_o : 1'b1;
  always #2.5 clock = ~clock;
  always @(posedge ss) rises++;
  spf_engine dut_u (.clock, .rst, .enable(en), .master_mode(1'b1), .frame_format(fmt),
    .clock_idle_polarity(pol), .clock_capture_phase(pha), .frame_length(flen),
    .control_word_length(clen), .data_direction_select(1'b0),
    .sequential_transfer_mode(seq), .ready_handshake_enable(1'b0),
    .frame_count_register(fcnt), .tx_data(txd), .tx_valid(txv), .tx_ready(txr),
    .rx_data(rxd), .rx_valid(rxv), .rx_ready(rxr), .busy, .serial_clock_line_in(sk),
    .serial_clock_line_out(sk_o), .serial_clock_line_oe(sk_e), .slave_select_pin_in(ss),
    .slave_select_pin_out(ss_o), .slave_select_pin_oe(ss_e),
    .serial_transmit_line_out(tx_o), .serial_transmit_line_oe(tx_e),
    .serial_receive_line_in(miso), .handshake_ready_in(1'b1));
  spf_peer peer_u (.sclk(sk), .cs_n(ss), .mosi(tx_o), .pol, .cpha(pha), .len(flen),
    .word(16'h00a5), .skip(fmt == 2'h2 ? {1'b0, clen} + 5'h2 : 5'h0), .miso, .rx(prx));
  task automatic finish_test;
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic fail_out;
    failures++;
    finish_test();
  endtask : fail_out
  task automatic cmp(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // Offer one word and hold it until taken
  task automatic put(input logic [15:0] w);
    int i;
    txd = w;
    txv = 1;
    for (i = 0; i < 900 && txr !== 1'b1; i++) tick(1);
    if (i == 900) fail_out();
    tick(1);
    txv = 0;
    tick(1);
  endtask : put
  task automatic pop(output logic [15:0] w);
    int i;
    for (i = 0; i < 300 && rxv !== 1'b1; i++) tick(1);
    if (i == 300) fail_out();
    w = rxd;
    rxr = 1;
    tick(1);
    rxr = 0;
    tick(1);
  endtask : pop
  task automatic idle;
    int i;
    tick(4);
    for (i = 0; i < 4000 && busy !== 1'b0; i++) tick(1);
    if (i == 4000) fail_out();
  endtask : idle
  // Single frame in one clock mode and length
  task automatic t_spi(input logic p, h, input logic [3:0] l);
    logic [15:0] m, w;
    pol = p;
    pha = h;
    flen = l;
    m = 16'hffff >> (4'hf - l);
    tick(4);
    put(16'h3c96);
    idle();
    pop(w);
    cmp(w, 16'h00a5 & m);
    cmp(prx & m, 16'h3c96 & m);
    cmp({15'h0, tx_e}, 16'h0);
    cmp({15'h0, sk}, {15'h0, p});
  endtask : t_spi
  // Back to back frames, select behaviour between them
  task automatic t_cont(input logic h);
    logic [15:0] w;
    pol = 0;
    pha = h;
    flen = 4'h7;
    tick(4);
    rises = 0;
    en = 0;
    put(16'h0081);
    tick(40);
    cmp({15'h0, busy}, 16'h0);
    en = 1;
    put(16'h007e);
    idle();
    repeat (2) begin
      pop(w);
      cmp(w, 16'h00a5);
    end
    cmp(prx & 16'h00ff, 16'h007e);
    cmp(rises, h ? 16'h1 : 16'h2);
  endtask : t_cont
  // Two frames with sync pulses
  task automatic t_ssp;
    logic [15:0] w;
    fmt = 2'h1;
    pha = 1;
    put(16'h0055);
    put(16'h00aa);
    idle();
    repeat (2) begin
      pop(w);
      cmp(w, 16'h00a5);
    end
    cmp({15'h0, rxv}, 16'h0);
    fmt = 2'h0;
    tick(4);
  endtask : t_ssp
  // Sequential receive takes its count from the port
  task automatic t_mw;
    logic [15:0] w;
    fmt = 2'h2;
    seq = 1;
    pha = 0;
    clen = 4'h2;
    fcnt = 16'h0002;
    put(16'h0005);
    idle();
    repeat (3) begin
      pop(w);
      cmp(w, 16'h00a5);
    end
    tick(20);
    cmp({15'h0, rxv}, 16'h0);
    fmt = 2'h0;
    seq = 0;
    tick(4);
  endtask : t_mw
  // Full buffer blocks the next start until a word is read
  task automatic t_full;
    logic [15:0] w;
    flen = 4'h3;
    repeat (33) begin
      put(16'h0003);
      idle();
    end
    put(16'h0003);
    tick(100);
    cmp({15'h0, busy}, 16'h0);
    repeat (34) begin
      pop(w);
      cmp(w, 16'h0005);
    end
  endtask : t_full
  initial begin
    tick(16);
    rst = 0;
    tick(2);
    t_spi(0, 0, 4'h7);
    t_spi(0, 1, 4'hf);
    t_spi(1, 0, 4'h3);
    t_spi(1, 1, 4'h7);
    t_cont(0);
    t_cont(1);
    t_ssp();
    t_mw();
    t_full();
    finish_test();
  end
endmodule : tb_spf_engine
bind spf_engine spf_engine_chk chk_u (.clock, .rst, .enable, .master_mode, .frame_format,
  .clock_idle_polarity, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .busy,
  .serial_clock_line_out, .slave_select_pin_out, .serial_transmit_line_oe);
`default_nettype wire
